// [src/spi_bus_trigger_decoder.sv]
`timescale 1ns/100ps
module spi_bus_trigger_decoder (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_select,
  input wire logic i_two_wire_mode,
  input wire logic i_cs_active_high,
  input wire logic i_sample_falling,
  input wire logic i_data_active_low,
  input wire logic i_lsb_first,
  input wire logic [spi_mon_pkg::WORD_SIZE_W-1:0] i_word_size,
  input wire logic [spi_mon_pkg::TIMEOUT_W-1:0] i_timeout_cycles,
  input wire logic i_capture_en,
  input wire logic [1:0] i_trig_mode,
  input wire logic [spi_mon_pkg::OFFSET_W-1:0] i_trig_bit,
  input wire logic [spi_mon_pkg::OFFSET_W-1:0] i_match_offset,
  input wire logic [spi_mon_pkg::WORD_SIZE_W-1:0] i_match_length,
  input wire logic [spi_mon_pkg::WORD_MAX-1:0] i_match_value,
  input wire logic [spi_mon_pkg::WORD_MAX-1:0] i_match_care,
  input wire logic i_match_hex,
  input wire logic [spi_mon_pkg::NIBBLES-1:0] i_match_nibble_care,
  output logic o_trigger,
  output logic o_frame_active,
  output logic o_word_valid,
  output logic [spi_mon_pkg::WORD_MAX-1:0] o_word_data,
  output logic o_frame_valid,
  output logic [spi_mon_pkg::COUNT_W-1:0] o_frame_words,
  output logic [spi_mon_pkg::TIME_W-1:0] o_frame_start_time,
  output logic [1:0] o_frame_status
);
  // Link-side capture: one toggle and one data sample per clock edge
  logic rise_tgl_reg;
  logic rise_tgl_next;
  logic rise_dat_reg;
  logic rise_dat_next;
  logic fall_tgl_reg;
  logic fall_tgl_next;
  logic fall_dat_reg;
  logic fall_dat_next;

  always_comb begin
    rise_tgl_next = ~rise_tgl_reg;
    rise_dat_next = i_sdata;
    fall_tgl_next = ~fall_tgl_reg;
    fall_dat_next = i_sdata;
  end

  // Both edges captured; the choice of edge is made after the crossing
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rise_tgl_reg <= 1'b0;
      rise_dat_reg <= 1'b0;
    end else begin
      rise_tgl_reg <= rise_tgl_next;
      rise_dat_reg <= rise_dat_next;
    end
  end

  always_ff @(negedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fall_tgl_reg <= 1'b0;
      fall_dat_reg <= 1'b0;
    end else begin
      fall_tgl_reg <= fall_tgl_next;
      fall_dat_reg <= fall_dat_next;
    end
  end

  // Data sample and its toggle share one path, so the sample is settled when the toggle is seen
  logic [spi_mon_pkg::SYNC_W-1:0] sync_out;
  sync3 #(
    .W(spi_mon_pkg::SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async({i_sclk, ~i_select, i_sdata, rise_tgl_reg, rise_dat_reg, fall_tgl_reg, fall_dat_reg}),
    .o_level(sync_out)
  );

  logic sclk_s;
  // Select enters inverted so the reset zeros read as an idle active-low select
  logic sel_n_s;
  logic dat_s;
  logic rtg_s;
  logic rdat_s;
  logic ftg_s;
  logic fdat_s;
  assign {sclk_s, sel_n_s, dat_s, rtg_s, rdat_s, ftg_s, fdat_s} = sync_out;

  spi_mon_pkg::frame_state_t state_reg;
  spi_mon_pkg::frame_state_t state_next;
  logic rtg_d_reg;
  logic ftg_d_reg;
  logic sel_act_d_reg;
  logic sel_act_d_next;
  logic [spi_mon_pkg::TIMEOUT_W-1:0] to_cnt_reg;
  logic [spi_mon_pkg::TIMEOUT_W-1:0] to_cnt_next;
  logic [spi_mon_pkg::COUNT_W-1:0] bit_cnt_reg;
  logic [spi_mon_pkg::COUNT_W-1:0] bit_cnt_next;
  logic [spi_mon_pkg::WORD_SIZE_W-1:0] wbit_reg;
  logic [spi_mon_pkg::WORD_SIZE_W-1:0] wbit_next;
  logic [spi_mon_pkg::COUNT_W-1:0] word_cnt_reg;
  logic [spi_mon_pkg::COUNT_W-1:0] word_cnt_next;
  logic [spi_mon_pkg::WORD_MAX-1:0] acc_reg;
  logic [spi_mon_pkg::WORD_MAX-1:0] acc_next;
  logic [spi_mon_pkg::WORD_MAX-1:0] hist_reg;
  logic [spi_mon_pkg::WORD_MAX-1:0] hist_next;
  logic partial_reg;
  logic partial_next;
  logic [spi_mon_pkg::TIME_W-1:0] time_reg;
  logic [spi_mon_pkg::TIME_W-1:0] start_stamp_reg;
  logic [spi_mon_pkg::TIME_W-1:0] start_stamp_next;
  logic [spi_mon_pkg::TIME_W-1:0] trig_time_reg;
  logic [spi_mon_pkg::TIME_W-1:0] trig_time_next;
  logic trigger_reg;
  logic trigger_next;
  logic word_valid_reg;
  logic word_valid_next;
  logic [spi_mon_pkg::WORD_MAX-1:0] word_data_reg;
  logic [spi_mon_pkg::WORD_MAX-1:0] word_data_next;
  logic frame_valid_reg;
  logic frame_valid_next;
  logic [spi_mon_pkg::COUNT_W-1:0] frame_words_reg;
  logic [spi_mon_pkg::COUNT_W-1:0] frame_words_next;
  logic [spi_mon_pkg::TIME_W-1:0] frame_time_reg;
  logic [spi_mon_pkg::TIME_W-1:0] frame_time_next;
  logic [1:0] frame_status_reg;
  logic [1:0] frame_status_next;

  logic sel_act;
  logic bit_ev;
  logic bit_val;
  logic idle_low;
  logic expire;
  logic frame_start;
  logic frame_end;
  logic active;
  logic word_done;
  logic bit_hit;
  logic pat_hit;
  logic [spi_mon_pkg::WORD_MAX-1:0] care_eff;
  logic [spi_mon_pkg::WORD_MAX-1:0] len_mask;
  logic [spi_mon_pkg::COUNT_W-1:0] pat_end;

  always_comb begin
    sel_act = sel_n_s ^ i_cs_active_high;
    bit_ev = i_sample_falling ? (ftg_s ^ ftg_d_reg) : (rtg_s ^ rtg_d_reg);
    bit_val = (i_sample_falling ? fdat_s : rdat_s) ^ i_data_active_low;
    idle_low = ~sclk_s & ~dat_s;
    // Fires once per idle stretch; the counter then saturates
    expire = idle_low && (to_cnt_reg + 20'h0_0001 == i_timeout_cycles);
    to_cnt_next = !idle_low ? spi_mon_pkg::TIMEOUT_RST :
                  (to_cnt_reg == i_timeout_cycles) ? to_cnt_reg : to_cnt_reg + 20'h0_0001;
    active = (state_reg == spi_mon_pkg::FR_ACTIVE);
    // Only select or timeout bound a frame; no address or acknowledge phase
    if (i_two_wire_mode) begin
      frame_start = expire;
      frame_end = expire && active;
    end else begin
      frame_start = sel_act && !sel_act_d_reg;
      frame_end = !sel_act && sel_act_d_reg && active;
    end
    sel_act_d_next = sel_act;

    for (int k = 0; k < spi_mon_pkg::WORD_MAX; k++) begin
      care_eff[k] = i_match_hex ? i_match_nibble_care[k/4] : i_match_care[k];
      len_mask[k] = (k < int'(i_match_length));
    end
    pat_end = spi_mon_pkg::COUNT_W'(i_match_offset) + spi_mon_pkg::COUNT_W'(i_match_length);

    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    wbit_next = wbit_reg;
    word_cnt_next = word_cnt_reg;
    acc_next = acc_reg;
    hist_next = hist_reg;
    partial_next = partial_reg;
    start_stamp_next = start_stamp_reg;
    trig_time_next = trig_time_reg;
    word_valid_next = 1'b0;
    word_data_next = word_data_reg;
    frame_valid_next = 1'b0;
    frame_words_next = frame_words_reg;
    frame_time_next = frame_time_reg;
    frame_status_next = frame_status_reg;
    word_done = 1'b0;
    bit_hit = 1'b0;
    pat_hit = 1'b0;

    if (frame_end) begin
      frame_valid_next = 1'b1;
      frame_words_next = word_cnt_reg;
      if (partial_reg || !i_capture_en) begin
        frame_status_next = spi_mon_pkg::STATUS_PARTIAL;
      end else if (word_cnt_reg == spi_mon_pkg::COUNT_RST) begin
        frame_status_next = spi_mon_pkg::STATUS_NO_DATA;
      end else begin
        frame_status_next = spi_mon_pkg::STATUS_OK;
      end
      state_next = spi_mon_pkg::FR_IDLE;
    end

    if (frame_start) begin
      state_next = spi_mon_pkg::FR_ACTIVE;
      bit_cnt_next = spi_mon_pkg::COUNT_RST;
      wbit_next = spi_mon_pkg::WBIT_RST;
      word_cnt_next = spi_mon_pkg::COUNT_RST;
      acc_next = spi_mon_pkg::WORD_RST;
      hist_next = spi_mon_pkg::WORD_RST;
      partial_next = !i_capture_en;
      start_stamp_next = time_reg;
    end else if (active && !frame_end) begin
      if (!i_capture_en) begin
        partial_next = 1'b1;
      end
      if (bit_ev) begin
        hist_next = {hist_reg[spi_mon_pkg::WORD_MAX-2:0], bit_val};
        if (i_lsb_first) begin
          acc_next[wbit_reg[4:0]] = bit_val;
        end else begin
          acc_next = {acc_reg[spi_mon_pkg::WORD_MAX-2:0], bit_val};
        end
        if (bit_cnt_reg != 16'hFFFF) begin
          bit_cnt_next = bit_cnt_reg + 16'h0001;
        end
        bit_hit = (bit_cnt_reg == spi_mon_pkg::COUNT_W'(i_trig_bit));
        // Bits ahead of the offset only shift through the history
        pat_hit = (bit_cnt_reg + 16'h0001 == pat_end) &&
                  (((hist_next ^ i_match_value) & care_eff & len_mask) == spi_mon_pkg::WORD_RST);
        word_done = (wbit_reg + 6'h01 >= i_word_size);
        if (word_done) begin
          word_valid_next = 1'b1;
          word_data_next = acc_next;
          acc_next = spi_mon_pkg::WORD_RST;
          wbit_next = spi_mon_pkg::WBIT_RST;
          word_cnt_next = word_cnt_reg + 16'h0001;
        end else begin
          wbit_next = wbit_reg + 6'h01;
        end
      end
    end

    unique case (i_trig_mode)
      spi_mon_pkg::TRIG_START: trigger_next = frame_start;
      spi_mon_pkg::TRIG_END: trigger_next = frame_end;
      spi_mon_pkg::TRIG_BIT: trigger_next = bit_hit;
      spi_mon_pkg::TRIG_PATTERN: trigger_next = pat_hit;
    endcase
    trig_time_next = trigger_next ? time_reg : trig_time_reg;
    if (frame_end) begin
      frame_time_next = start_stamp_reg - trig_time_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= spi_mon_pkg::FR_IDLE;
      rtg_d_reg <= 1'b0;
      ftg_d_reg <= 1'b0;
      sel_act_d_reg <= 1'b0;
      to_cnt_reg <= spi_mon_pkg::TIMEOUT_RST;
      bit_cnt_reg <= spi_mon_pkg::COUNT_RST;
      wbit_reg <= spi_mon_pkg::WBIT_RST;
      word_cnt_reg <= spi_mon_pkg::COUNT_RST;
      acc_reg <= spi_mon_pkg::WORD_RST;
      hist_reg <= spi_mon_pkg::WORD_RST;
      partial_reg <= 1'b0;
      time_reg <= spi_mon_pkg::TIME_RST;
      start_stamp_reg <= spi_mon_pkg::TIME_RST;
      trig_time_reg <= spi_mon_pkg::TIME_RST;
      trigger_reg <= 1'b0;
      word_valid_reg <= 1'b0;
      word_data_reg <= spi_mon_pkg::WORD_RST;
      frame_valid_reg <= 1'b0;
      frame_words_reg <= spi_mon_pkg::COUNT_RST;
      frame_time_reg <= spi_mon_pkg::TIME_RST;
      frame_status_reg <= spi_mon_pkg::STATUS_OK;
    end else if (i_ce) begin
      state_reg <= state_next;
      rtg_d_reg <= rtg_s;
      ftg_d_reg <= ftg_s;
      sel_act_d_reg <= sel_act_d_next;
      to_cnt_reg <= to_cnt_next;
      bit_cnt_reg <= bit_cnt_next;
      wbit_reg <= wbit_next;
      word_cnt_reg <= word_cnt_next;
      acc_reg <= acc_next;
      hist_reg <= hist_next;
      partial_reg <= partial_next;
      time_reg <= time_reg + 32'h0000_0001;
      start_stamp_reg <= start_stamp_next;
      trig_time_reg <= trig_time_next;
      trigger_reg <= trigger_next;
      word_valid_reg <= word_valid_next;
      word_data_reg <= word_data_next;
      frame_valid_reg <= frame_valid_next;
      frame_words_reg <= frame_words_next;
      frame_time_reg <= frame_time_next;
      frame_status_reg <= frame_status_next;
    end
  end

  assign o_trigger = trigger_reg;
  assign o_frame_active = state_reg[1];
  assign o_word_valid = word_valid_reg;
  assign o_word_data = word_data_reg;
  assign o_frame_valid = frame_valid_reg;
  assign o_frame_words = frame_words_reg;
  assign o_frame_start_time = frame_time_reg;
  assign o_frame_status = frame_status_reg;
endmodule

// [src/spi_mon_pkg.sv]
package spi_mon_pkg;
  localparam int WORD_MAX = 32;
  localparam int WORD_SIZE_W = 6;
  localparam int OFFSET_W = 12;
  localparam int COUNT_W = 16;
  localparam int TIME_W = 32;
  localparam int TIMEOUT_W = 20;
  localparam int NIBBLES = 8;
  localparam int SYNC_W = 7;

  // Trigger condition select
  localparam logic [1:0] TRIG_START = 2'h0;
  localparam logic [1:0] TRIG_END = 2'h1;
  localparam logic [1:0] TRIG_BIT = 2'h2;
  localparam logic [1:0] TRIG_PATTERN = 2'h3;

  // Frame status codes
  localparam logic [1:0] STATUS_OK = 2'h0;
  localparam logic [1:0] STATUS_NO_DATA = 2'h1;
  localparam logic [1:0] STATUS_PARTIAL = 2'h2;

  // Reset values
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [TIME_W-1:0] TIME_RST = 32'h0000_0000;
  localparam logic [WORD_MAX-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_RST = 20'h0_0000;
  localparam logic [WORD_SIZE_W-1:0] WBIT_RST = 6'h00;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b01,
    FR_ACTIVE = 2'b10
  } frame_state_t;
endpackage

// [src/sync3.sv]
`timescale 1ns/100ps
module sync3 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // A change is accepted only once stages two and three agree
  always_comb begin
    out_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & out_reg);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else if (i_ce) begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign o_level = out_reg;
endmodule

// [verif/spi_master_model.sv]
`timescale 1ns/100ps
module spi_master_model (
  output logic o_sclk,
  output logic o_sdata,
  output logic o_select
);
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_select = 1'b1;
  end
  // Idle select follows the polarity; two-wire idle means low lines
  task automatic park(input logic csh, input logic tw);
    // A short pulse restarts the idle count, so a fresh timeout follows
    if (tw) begin
      o_sdata = 1'b1;
      #20 o_sdata = 1'b0;
    end else begin
      o_select = ~csh;
    end
  endtask
  // Clock stands still outside frames; 30 ns period, edges off the system clock grid
  task automatic frame(input logic [31:0] v, input int n, input logic csh, input logic tw);
    if (!tw) begin
      o_select = csh;
    end
    #43;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdata = v[i];
      #7.5 o_sclk = 1'b1;
      #15 o_sclk = 1'b0;
      #7.5;
    end
    #40;
    if (!tw) begin
      o_select = ~csh;
    end
    o_sdata = tw ? 1'b0 : ~o_sdata;
  endtask
endmodule

// [verif/spi_mon_checker.sv]
`timescale 1ns/100ps
module spi_mon_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_select,
  input wire logic i_two_wire_mode,
  input wire logic i_cs_active_high,
  input wire logic [spi_mon_pkg::TIMEOUT_W-1:0] i_timeout_cycles,
  input wire logic o_trigger,
  input wire logic o_frame_active,
  input wire logic o_word_valid,
  input wire logic [spi_mon_pkg::WORD_MAX-1:0] o_word_data,
  input wire logic o_frame_valid,
  input wire logic [spi_mon_pkg::COUNT_W-1:0] o_frame_words,
  input wire logic [1:0] o_frame_status
);
  // Saturates so long pauses cannot wrap
  logic [20:0] idle_reg;
  logic [20:0] idle_next;
  always_comb begin
    idle_next = idle_reg + 21'h0_0001;
    if (i_sclk || i_sdata) begin
      idle_next = 21'h0_0000;
    end else if (&idle_reg) begin
      idle_next = idle_reg;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_reg <= 21'h0_0000;
    end else begin
      idle_reg <= idle_next;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence cs_to_active;
    !i_two_wire_mode && $changed(i_select) && (i_select == i_cs_active_high);
  endsequence
  sequence cs_to_idle;
    !i_two_wire_mode && $changed(i_select) && (i_select != i_cs_active_high) ##0 o_frame_active;
  endsequence
  chk_start_seen: assert property (cs_to_active |-> ##[2:8] o_frame_active)
    else $error("frame did not open");
  chk_end_seen: assert property (cs_to_idle |-> ##[2:8] o_frame_valid)
    else $error("frame did not close");
  chk_close_drop: assert property (o_frame_valid && !i_two_wire_mode |-> ##[0:1] !o_frame_active)
    else $error("frame still open");
  chk_idle_gap: assert property (o_frame_valid && i_two_wire_mode |-> idle_reg >= 21'(i_timeout_cycles))
    else $error("timeout boundary too early");
  chk_trig_pulse: assert property (o_trigger |=> !o_trigger)
    else $error("trigger too long");
  chk_word_pulse: assert property (o_word_valid |=> !o_word_valid)
    else $error("word pulse too long");
  chk_word_hold: assert property ($changed(o_word_data) |-> o_word_valid)
    else $error("word changed alone");
  chk_frame_hold: assert property ($changed(o_frame_words) || $changed(o_frame_status) |-> o_frame_valid)
    else $error("frame result changed alone");
  chk_word_framed: assert property (o_word_valid |-> $past(o_frame_active))
    else $error("word outside frame");
  chk_nodata_zero: assert property (o_frame_valid && o_frame_status == 2'h1 |-> o_frame_words == 16'h0000)
    else $error("no-data frame with words");
endmodule
bind spi_bus_trigger_decoder spi_mon_checker chk_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_sdata(i_sdata), .i_select(i_select),
  .i_two_wire_mode(i_two_wire_mode), .i_cs_active_high(i_cs_active_high), .i_timeout_cycles(i_timeout_cycles),
  .o_trigger(o_trigger), .o_frame_active(o_frame_active), .o_word_valid(o_word_valid),
  .o_word_data(o_word_data), .o_frame_valid(o_frame_valid), .o_frame_words(o_frame_words),
  .o_frame_status(o_frame_status)
);

// [verif/tb.sv]
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [3:0] cfg;
    logic [5:0] ws;
    logic [31:0] v;
    logic [5:0] n;
    logic [3:0] words;
    logic [31:0] last;
    logic [1:0] mode;
    logic [11:0] tbit;
    logic [7:0] mval;
    logic [7:0] care;
    logic [7:0] ncare;
    logic trig;
  } row_t;
  // cfg is {lsb first, data active low, select active high, falling edge}
  row_t rows [14] = '{
    '{4'h0,6'h08,32'h0000_00A5,6'h08,4'h1,32'h0000_00A5,2'h0,12'h000,8'h00,8'h00,8'h00,1'h1},
    '{4'h8,6'h08,32'h0000_001C,6'h08,4'h1,32'h0000_0038,2'h0,12'h000,8'h00,8'h00,8'h00,1'h1},
    '{4'h4,6'h08,32'h0000_00A5,6'h08,4'h1,32'h0000_005A,2'h0,12'h000,8'h00,8'h00,8'h00,1'h1},
    '{4'h2,6'h08,32'h0000_003C,6'h08,4'h1,32'h0000_003C,2'h0,12'h000,8'h00,8'h00,8'h00,1'h1},
    '{4'h1,6'h08,32'h0000_00C3,6'h08,4'h1,32'h0000_00C3,2'h0,12'h000,8'h00,8'h00,8'h00,1'h1},
    '{4'h0,6'h01,32'h0000_0005,6'h03,4'h3,32'h0000_0001,2'h0,12'h000,8'h00,8'h00,8'h00,1'h1},
    '{4'h0,6'h20,32'hDEAD_BEEF,6'h20,4'h1,32'hDEAD_BEEF,2'h0,12'h000,8'h00,8'h00,8'h00,1'h1},
    '{4'h0,6'h05,32'h0000_0ABC,6'h0C,4'h2,32'h0000_000F,2'h0,12'h000,8'h00,8'h00,8'h00,1'h1},
    '{4'h0,6'h08,32'h0000_7A5E,6'h10,4'h2,32'h0000_005E,2'h1,12'h000,8'h00,8'h00,8'h00,1'h1},
    '{4'h0,6'h08,32'h0000_7A5E,6'h10,4'h2,32'h0000_005E,2'h2,12'h005,8'h00,8'h00,8'h00,1'h1},
    '{4'h0,6'h08,32'h0000_7A5E,6'h10,4'h2,32'h0000_005E,2'h3,12'h000,8'hA5,8'hFF,8'h00,1'h1},
    '{4'h0,6'h08,32'h0000_7A5E,6'h10,4'h2,32'h0000_005E,2'h3,12'h000,8'hA4,8'hFE,8'h00,1'h1},
    '{4'h0,6'h08,32'h0000_7A5E,6'h10,4'h2,32'h0000_005E,2'h3,12'h000,8'hF5,8'h00,8'h01,1'h1},
    '{4'h0,6'h08,32'h0000_7A5E,6'h10,4'h2,32'h0000_005E,2'h3,12'h000,8'hA4,8'h00,8'h01,1'h0}
  };
  logic clk, rst_n, sclk, sdata, sel, two_wire, cs_high, fall, inv, lsb, cap, mhex, trig, active, wv, fv;
  logic [5:0] ws, mlen;
  logic [1:0] mode, fstat;
  logic [11:0] tbit, moff;
  logic [19:0] tmo;
  logic [31:0] mval, mcare, wdata, lastw, fstart;
  logic [7:0] mncare;
  logic [15:0] fwords;
  int failures, num_checks, tcnt, tbase;
  row_t r;
  spi_master_model m_u (.o_sclk(sclk), .o_sdata(sdata), .o_select(sel));
  spi_bus_trigger_decoder dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_sclk(sclk), .i_sdata(sdata), .i_select(sel),
    .i_two_wire_mode(two_wire), .i_cs_active_high(cs_high), .i_sample_falling(fall), .i_data_active_low(inv),
    .i_lsb_first(lsb), .i_word_size(ws), .i_timeout_cycles(tmo), .i_capture_en(cap), .i_trig_mode(mode),
    .i_trig_bit(tbit), .i_match_offset(moff), .i_match_length(mlen), .i_match_value(mval),
    .i_match_care(mcare), .i_match_hex(mhex), .i_match_nibble_care(mncare), .o_trigger(trig),
    .o_frame_active(active), .o_word_valid(wv), .o_word_data(wdata), .o_frame_valid(fv),
    .o_frame_words(fwords), .o_frame_start_time(fstart), .o_frame_status(fstat)
  );
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (wv === 1'b1) begin
      lastw <= wdata;
    end
    if (trig === 1'b1) begin
      tcnt <= tcnt + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Idle wait also exceeds the two-wire timeout, so each run starts a fresh frame
  task automatic run(input logic [31:0] v, input int n, input int reps);
    int k;
    @(negedge clk);
    m_u.park(cs_high, two_wire);
    repeat (30) @(negedge clk);
    tbase = tcnt;
    for (int j = 0; j < reps; j++) begin
      m_u.frame(v, n, cs_high, two_wire);
    end
    for (k = 0; fv !== 1'b1 && k < 600; k++) begin
      @(negedge clk);
    end
    chk(32'(k < 600), 32'h0000_0001);
    repeat (4) @(negedge clk);
  endtask
  initial begin
    {clk, rst_n, two_wire, cs_high, fall, inv, lsb, mhex} = 8'h00;
    {cap, ws, mode, tbit, mncare} = 29'h1000_0000 | 29'h0200_0000;
    {mval, mcare} = 64'h0000_0000_0000_0000;
    {failures, num_checks} = 64'h0;
    {moff, mlen, tmo} = {12'h004, 6'h08, 20'h0_0014};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(negedge clk);
    chk(32'(active), 32'h0000_0000);
    for (int i = 0; i < 14; i++) begin
      r = rows[i];
      @(posedge clk);
      {lsb, inv, cs_high, fall} <= r.cfg;
      {ws, mode, tbit, mncare} <= {r.ws, r.mode, r.tbit, r.ncare};
      {mval, mcare} <= {32'(r.mval), 32'(r.care)};
      mhex <= (r.ncare != 8'h00);
      run(r.v, r.n, 1);
      chk(32'(fwords), 32'(r.words));
      chk(lastw, r.last);
      chk(32'(fstat), 32'(spi_mon_pkg::STATUS_OK));
      chk(32'(tcnt - tbase), 32'(r.trig));
      if (r.mode == spi_mon_pkg::TRIG_START) begin
        chk(fstart, 32'h0000_0000);
      end else begin
        chk(32'(fstart[31]), 32'(r.trig));
      end
    end
    @(posedge clk);
    {moff, mlen, mhex} <= {12'h000, 6'h04, 1'b0};
    {mval, mcare} <= {32'h0000_0007, 32'h0000_000F};
    run(32'h0000_7A5E, 16, 1);
    chk(32'(tcnt - tbase), 32'h0000_0001);
    run(32'h0000_0000, 0, 1);
    chk(32'(fstat), 32'(spi_mon_pkg::STATUS_NO_DATA));
    chk(32'(fwords), 32'h0000_0000);
    @(posedge clk);
    cap <= 1'b0;
    run(32'h0000_00A5, 8, 1);
    chk(32'(fstat), 32'(spi_mon_pkg::STATUS_PARTIAL));
    @(posedge clk);
    {cap, two_wire} <= 2'h3;
    tmo <= 20'h0_0010;
    run(32'h0000_00A5, 8, 2);
    chk(32'(fwords), 32'h0000_0002);
  print_verdict();
  end
  initial begin
    #(400_000);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule
